// ===== sbc_regs.vh
// Purpose: shared constants of the host link and bus pin control block
// Assumes: a 250 MHz system clock
// Notes:   times are given in their own unit, cycle counts are derived from them
`ifndef SBC_REGS_VH
`define SBC_REGS_VH

// system clock rate
`define SBC_CLK_MHZ          250

// frame length in serial clock bits
`define SBC_FRAME_BITS       4'h8

// command byte layout: [7:5] target, [4:0] data
`define SBC_CMD_TGT_MSB      7
`define SBC_CMD_TGT_LSB      5
`define SBC_TGT_MODE         3'h0
`define SBC_TGT_HIGH_SIDE    3'h1
`define SBC_TGT_LOW_SIDE     3'h2
`define SBC_TGT_MUX          3'h3
`define SBC_TGT_STATUS_READ  3'h4

// mode request codes in data[1:0] of a mode command
`define SBC_REQ_NORMAL       2'h0
`define SBC_REQ_STOP         2'h1
`define SBC_REQ_SLEEP        2'h2

// high side control data bits
`define SBC_HS_ON_BIT        0
`define SBC_HS_PWM_BIT       1
// low side control data bits
`define SBC_LS1_ON_BIT       0
`define SBC_LS2_ON_BIT       1
`define SBC_LS_PWM_BIT       2

// status byte bit positions; mode code sits in [7:5]
`define SBC_ST_CS_WAKE       0
`define SBC_ST_BUS_WAKE      1
`define SBC_ST_TXD_DOM       2
`define SBC_ST_FAULT         3

// reset values
`define SBC_MUX_RST          2'h0
`define SBC_FLAGS_RST        4'h0

// timing: figures in their own unit
`define SBC_RST_DEGLITCH_NS  600
`define SBC_STOP_WAKE_NS     13000
`define SBC_BUS_DEGLITCH_US  70
`define SBC_CS_HOLDOFF_US    90
`define SBC_RST_PULSE_US     1000
`define SBC_TXD_DOM_MS       1000

// timing: derived cycle counts
`define SBC_RST_DEGLITCH_CYC (`SBC_RST_DEGLITCH_NS * `SBC_CLK_MHZ / 1000)
`define SBC_STOP_WAKE_CYC    (`SBC_STOP_WAKE_NS * `SBC_CLK_MHZ / 1000)
`define SBC_BUS_DEGLITCH_CYC (`SBC_BUS_DEGLITCH_US * `SBC_CLK_MHZ)
`define SBC_CS_HOLDOFF_CYC   (`SBC_CS_HOLDOFF_US * `SBC_CLK_MHZ)
`define SBC_RST_PULSE_CYC    (`SBC_RST_PULSE_US * `SBC_CLK_MHZ)
`define SBC_TXD_DOM_CYC      (`SBC_TXD_DOM_MS * `SBC_CLK_MHZ * 1000)

`endif

// ===== sbc_sync3.v
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: the pin is asynchronous to clk_sys_i
// Notes:   the output moves only once stages two and three agree
`timescale 1ns/1ns
module sbc_sync3 #(
	parameter RST_VAL = 1'b1
) (
	// clock and control
	input  wire clk_sys_i,
	input  wire sys_rst_i,
	input  wire ce_i,
	// pin and result
	input  wire pin_i,
	output reg  level_o
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	// first stage feeds only the second, the filter looks at two and three
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			s1_reg  <= RST_VAL;
			s2_reg  <= RST_VAL;
			s3_reg  <= RST_VAL;
			level_o <= RST_VAL;
		end else if (ce_i) begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_o <= s3_reg;
			end
		end
	end
endmodule

// ===== sbc_link.v
// Purpose: host serial link, bus pin logic, switch gating, reset and interrupt pins
// Assumes: 250 MHz clk_sys_i, serial clock well below a quarter of it
// Notes:   all pins are oversampled; no state moves while ce_i is low
// Operation
// - mosi taken on serial clock rise, miso changed on serial clock fall
// - miso output enable only while chip select is low
// - frame latched and executed at the chip select rising edge
// - a valid frame holds exactly eight bits
// - chip select rising edge in stop mode raises a wake-up
// - receive output low while bus dominant, high while recessive
// - bus dominant when transmit input low, recessive when high or floating
// - transmitter works only in normal and normal request modes
// - transmit input dominant for one second flags permanent dominant
// - bus wake in sleep needs dominant through 70 us filter, in stop any dominant level starts the wake
// - bus wake in stop pulls interrupt low 9 to 17 us later
// - pulse gate input drives switches only in normal request or normal
// - pulse gating stays off until a switch control write enables it
// - reset pin two-way active low; release leads to normal request
// - interrupt signals events in active modes and wake from stop
// - in active modes the interrupt clears only after a status read over the link
// - mux select routes battery, wake one, wake two or temperature
// - stop entered within 5 us of the frame ending a stop command
// - reset input deglitched 600 ns before an external reset counts
`timescale 1ns/1ns
`include "sbc_regs.vh"
module sbc_link #(
	parameter BUS_DEGLITCH_CYC = `SBC_BUS_DEGLITCH_CYC,
	parameter CS_HOLDOFF_CYC   = `SBC_CS_HOLDOFF_CYC,
	parameter RST_PULSE_CYC    = `SBC_RST_PULSE_CYC,
	parameter TXD_DOM_CYC      = `SBC_TXD_DOM_CYC
) (
	// clock, reset, enable
	input  wire       clk_sys_i,
	input  wire       sys_rst_i,
	input  wire       ce_i,
	// serial host link
	input  wire       sclk_i,
	input  wire       cs_n_i,
	input  wire       mosi_i,
	output reg        miso_o,
	output reg        miso_oe_o,
	// single-wire bus and its logic pins
	input  wire       txd_i,
	output reg        rxd_o,
	input  wire       lin_bus_i,
	output reg        lin_bus_o,
	output reg        lin_bus_oe_o,
	// switches
	input  wire       pulse_gate_input_i,
	output reg        high_side_switch_o,
	output reg  [1:0] low_side_switch_o,
	// reset pin, open drain
	input  wire       rst_n_i,
	output reg        rst_n_o,
	output reg        rst_n_oe_o,
	// interrupt and events
	input  wire       fault_event_i,
	input  wire       internal_reset_req_i,
	output reg        irq_n_o,
	// analog mux and mode
	output reg  [1:0] analog_mux_output_sel_o,
	output reg  [2:0] mode_o
);
	// operating modes
	localparam [2:0] M_RESET  = 3'h0;
	localparam [2:0] M_NREQ   = 3'h1;
	localparam [2:0] M_NORMAL = 3'h2;
	localparam [2:0] M_STOP   = 3'h3;
	localparam [2:0] M_SLEEP  = 3'h4;
	localparam STOP_WAKE_CYC    = `SBC_STOP_WAKE_CYC;
	localparam RST_DEGLITCH_CYC = `SBC_RST_DEGLITCH_CYC;

	wire sclk_s;
	wire cs_n_s;
	wire mosi_s;
	wire txd_s;
	wire pwm_s;
	wire rst_n_s;
	wire bus_s;

	reg        sclk_d_reg;
	reg        cs_n_d_reg;
	reg  [2:0] mode_reg;
	reg  [7:0] shift_in_reg;
	reg  [7:0] shift_out_reg;
	reg  [3:0] bit_cnt_reg;
	reg  [3:0] flags_reg;
	reg  [3:0] snap_reg;
	reg        hs_on_reg;
	reg        hs_pwm_reg;
	reg  [1:0] ls_on_reg;
	reg        ls_pwm_reg;
	reg  [1:0] mux_reg;
	reg  [27:0] dom_cnt_reg;
	reg        dom_lock_reg;
	reg  [14:0] bus_cnt_reg;
	reg  [11:0] rep_cnt_reg;
	reg        rep_busy_reg;
	reg  [14:0] hold_cnt_reg;
	reg  [17:0] rst_cnt_reg;
	reg  [7:0] rstf_cnt_reg;
	reg        ext_rst_reg;

	wire sclk_rise = sclk_s & ~sclk_d_reg;
	wire sclk_fall = ~sclk_s & sclk_d_reg;
	wire cs_fall   = ~cs_n_s & cs_n_d_reg;
	wire cs_rise   = cs_n_s & ~cs_n_d_reg;
	wire frame_ok  = cs_rise && bit_cnt_reg == `SBC_FRAME_BITS && hold_cnt_reg == 15'h0000;
	wire [2:0] tgt = shift_in_reg[`SBC_CMD_TGT_MSB:`SBC_CMD_TGT_LSB];
	wire active    = mode_reg == M_NREQ || mode_reg == M_NORMAL;
	wire low_power = mode_reg == M_STOP || mode_reg == M_SLEEP;
	wire cs_wake   = cs_rise && mode_reg == M_STOP;
	wire bus_wake  = low_power && !bus_s &&
	                 bus_cnt_reg == BUS_DEGLITCH_CYC[14:0] - 15'h0001;
	wire dom_hit   = active && !txd_s && !dom_lock_reg &&
	                 dom_cnt_reg == TXD_DOM_CYC[27:0] - 28'h0000001;
	wire rep_done  = rep_busy_reg && rep_cnt_reg == STOP_WAKE_CYC[11:0] - 12'h001;
	wire rst_ext   = !rst_n_s && !rst_n_oe_o &&
	                 rstf_cnt_reg == RST_DEGLITCH_CYC[7:0] - 8'h01;
	wire status_rd = frame_ok && tgt == `SBC_TGT_STATUS_READ;
	reg  [3:0] flags_next;

	// pin synchronisers; the serial clock is just another sampled pin
	sbc_sync3 #(.RST_VAL(1'b0)) u_sync_sclk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce_i), .pin_i(sclk_i), .level_o(sclk_s));
	sbc_sync3 #(.RST_VAL(1'b1)) u_sync_cs (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce_i), .pin_i(cs_n_i), .level_o(cs_n_s));
	sbc_sync3 #(.RST_VAL(1'b0)) u_sync_mosi (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce_i), .pin_i(mosi_i), .level_o(mosi_s));
	sbc_sync3 #(.RST_VAL(1'b1)) u_sync_txd (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce_i), .pin_i(txd_i), .level_o(txd_s));
	sbc_sync3 #(.RST_VAL(1'b0)) u_sync_pwm (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce_i), .pin_i(pulse_gate_input_i), .level_o(pwm_s));
	sbc_sync3 #(.RST_VAL(1'b1)) u_sync_rst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce_i), .pin_i(rst_n_i), .level_o(rst_n_s));
	sbc_sync3 #(.RST_VAL(1'b1)) u_sync_bus (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce_i), .pin_i(lin_bus_i), .level_o(bus_s));

	// serial shifting; mosi on rise, miso on fall, bits counted saturating at 9
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sclk_d_reg    <= 1'b0;
			cs_n_d_reg    <= 1'b1;
			shift_in_reg  <= 8'h00;
			shift_out_reg <= 8'h00;
			bit_cnt_reg   <= 4'h0;
			snap_reg      <= 4'h0;
			miso_o        <= 1'b0;
			miso_oe_o     <= 1'b0;
		end else if (ce_i) begin
			sclk_d_reg <= sclk_s;
			cs_n_d_reg <= cs_n_s;
			miso_oe_o  <= ~cs_n_s;
			if (cs_fall) begin
				// status snapshot: only bits shown here may be cleared by the read
				snap_reg      <= flags_reg;
				shift_out_reg <= {mode_reg, 1'b0, flags_reg};
				miso_o        <= mode_reg[2];
				bit_cnt_reg   <= 4'h0;
			end else if (!cs_n_s) begin
				if (sclk_rise) begin
					shift_in_reg <= {shift_in_reg[6:0], mosi_s};
					if (bit_cnt_reg != 4'h9) begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				if (sclk_fall) begin
					shift_out_reg <= {shift_out_reg[6:0], 1'b0};
					miso_o        <= shift_out_reg[6];
				end
			end
		end
	end

	// status flags: a new event wins over the clear from a status read
	always @* begin
		flags_next = flags_reg;
		if (status_rd) begin
			flags_next = flags_reg & ~snap_reg;
		end
		if (cs_wake) begin
			flags_next[`SBC_ST_CS_WAKE] = 1'b1;
		end
		if (rep_done) begin
			flags_next[`SBC_ST_BUS_WAKE] = 1'b1;
		end
		if (dom_hit) begin
			flags_next[`SBC_ST_TXD_DOM] = 1'b1;
		end
		if (fault_event_i && active) begin
			flags_next[`SBC_ST_FAULT] = 1'b1;
		end
	end

	// mode sequencing and command execution; only whole frames are acted on
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mode_reg     <= M_RESET;
			flags_reg    <= `SBC_FLAGS_RST;
			hs_on_reg    <= 1'b0;
			hs_pwm_reg   <= 1'b0;
			ls_on_reg    <= 2'h0;
			ls_pwm_reg   <= 1'b0;
			mux_reg      <= `SBC_MUX_RST;
			rst_cnt_reg  <= 18'h00000;
			hold_cnt_reg <= 15'h0000;
		end else if (ce_i) begin
			flags_reg <= flags_next;
			if (hold_cnt_reg != 15'h0000) begin
				hold_cnt_reg <= hold_cnt_reg - 15'h0001;
			end
			case (mode_reg)
				M_RESET: begin
					// device holds the reset pin low for the pulse length
					if (rst_cnt_reg == RST_PULSE_CYC[17:0] - 18'h00001) begin
						rst_cnt_reg <= 18'h00000;
						mode_reg    <= M_NREQ;
					end else begin
						rst_cnt_reg <= rst_cnt_reg + 18'h00001;
					end
				end
				M_NREQ, M_NORMAL: begin
					if (internal_reset_req_i) begin
						mode_reg <= M_RESET;
					end else if (frame_ok) begin
						case (tgt)
							`SBC_TGT_MODE: begin
								case (shift_in_reg[1:0])
									`SBC_REQ_NORMAL: mode_reg <= M_NORMAL;
									`SBC_REQ_STOP:   mode_reg <= M_STOP;
									`SBC_REQ_SLEEP:  mode_reg <= M_SLEEP;
									default:         mode_reg <= mode_reg;
								endcase
							end
							`SBC_TGT_HIGH_SIDE: begin
								hs_on_reg  <= shift_in_reg[`SBC_HS_ON_BIT];
								hs_pwm_reg <= shift_in_reg[`SBC_HS_PWM_BIT];
							end
							`SBC_TGT_LOW_SIDE: begin
								ls_on_reg  <= {shift_in_reg[`SBC_LS2_ON_BIT],
								               shift_in_reg[`SBC_LS1_ON_BIT]};
								ls_pwm_reg <= shift_in_reg[`SBC_LS_PWM_BIT];
							end
							`SBC_TGT_MUX: begin
								mux_reg <= shift_in_reg[1:0];
							end
							default: begin
								mux_reg <= mux_reg;
							end
						endcase
					end
				end
				M_STOP: begin
					// chip select or a reported bus wake returns to normal request
					if (cs_wake) begin
						mode_reg     <= M_NREQ;
						hold_cnt_reg <= CS_HOLDOFF_CYC[14:0];
					end else if (rep_done) begin
						mode_reg <= M_NREQ;
					end
				end
				M_SLEEP: begin
					// supply is off in sleep, so a wake restarts through reset
					if (bus_wake) begin
						mode_reg <= M_RESET;
					end
				end
				default: begin
					mode_reg <= M_RESET;
				end
			endcase
			if (rst_ext) begin
				mode_reg <= M_NREQ;
			end
		end
	end

	// permanent dominant watch; locks the driver off until transmit goes high or the mode leaves the active modes
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			dom_cnt_reg  <= 28'h0000000;
			dom_lock_reg <= 1'b0;
		end else if (ce_i) begin
			if (txd_s || !active) begin
				dom_cnt_reg  <= 28'h0000000;
				dom_lock_reg <= 1'b0;
			end else if (dom_hit) begin
				dom_lock_reg <= 1'b1;
			end else if (!dom_lock_reg) begin
				dom_cnt_reg <= dom_cnt_reg + 28'h0000001;
			end
		end
	end

	// bus wake filter and stop-mode report delay
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			bus_cnt_reg  <= 15'h0000;
			rep_cnt_reg  <= 12'h000;
			rep_busy_reg <= 1'b0;
		end else if (ce_i) begin
			if (!low_power || bus_s || bus_wake) begin
				bus_cnt_reg <= 15'h0000;
			end else begin
				bus_cnt_reg <= bus_cnt_reg + 15'h0001;
			end
			// the report timer starts at the threshold crossing, not after the filter
			if (mode_reg != M_STOP || rep_done) begin
				rep_busy_reg <= 1'b0;
				rep_cnt_reg  <= 12'h000;
			end else if (rep_busy_reg) begin
				rep_cnt_reg <= rep_cnt_reg + 12'h001;
			end else if (!bus_s) begin
				rep_busy_reg <= 1'b1;
			end
		end
	end

	// reset pin: deglitch the input while not driving it ourselves
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rstf_cnt_reg <= 8'h00;
			ext_rst_reg  <= 1'b0;
		end else if (ce_i) begin
			if (rst_n_s || rst_n_oe_o) begin
				rstf_cnt_reg <= 8'h00;
				ext_rst_reg  <= 1'b0;
			end else if (rst_ext) begin
				ext_rst_reg <= 1'b1;
			end else if (!ext_rst_reg) begin
				rstf_cnt_reg <= rstf_cnt_reg + 8'h01;
			end
		end
	end

	// registered pin outputs
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rxd_o                   <= 1'b1;
			lin_bus_o               <= 1'b0;
			lin_bus_oe_o            <= 1'b0;
			high_side_switch_o      <= 1'b0;
			low_side_switch_o       <= 2'h0;
			rst_n_o                 <= 1'b0;
			rst_n_oe_o              <= 1'b1;
			irq_n_o                 <= 1'b1;
			analog_mux_output_sel_o <= `SBC_MUX_RST;
			mode_o                  <= M_RESET;
		end else if (ce_i) begin
			rxd_o        <= bus_s;
			// floating transmit reads high at the pin, hence recessive
			lin_bus_oe_o <= active && !txd_s && !dom_lock_reg;
			if (active) begin
				// gating is useful only up to the pin rate the master keeps to
				high_side_switch_o <= hs_pwm_reg ? (hs_on_reg & pwm_s) : hs_on_reg;
				low_side_switch_o  <= ls_pwm_reg ? (ls_on_reg & {2{pwm_s}})
				                                 : ls_on_reg;
			end else begin
				high_side_switch_o <= 1'b0;
				low_side_switch_o  <= 2'h0;
			end
			rst_n_oe_o <= mode_reg == M_RESET;
			// active modes report any flag, stop reports only the bus wake
			irq_n_o <= ~((active && flags_next != 4'h0) ||
			             (mode_reg == M_STOP && rep_done));
			analog_mux_output_sel_o <= mux_reg;
			mode_o                  <= mode_reg;
		end
	end
endmodule

// ===== sbc_link_assertions.sv
// Purpose: pin timing relations of the host link and bus pin block
// Assumes: one clock domain, synchronous active high reset
// Notes:   long waits use helper counters, not repetitions
`timescale 1ns/1ns
module sbc_link_assertions #(
	parameter TXD_DOM_CYC = 50
) (
	// clock and reset
	input wire       clk_sys_i,
	input wire       sys_rst_i,
	// watched pins
	input wire       cs_n_i,
	input wire       miso_oe_o,
	input wire       txd_i,
	input wire       lin_bus_i,
	input wire       rxd_o,
	input wire       lin_bus_oe_o,
	input wire       high_side_switch_o,
	input wire [1:0] low_side_switch_o,
	input wire       rst_n_oe_o,
	input wire       irq_n_o,
	input wire [2:0] mode_o
);
	reg [12:0] wake_cnt;
	integer    dom_cnt;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_lowpow;
		(mode_o == 3'h0 || mode_o == 3'h3 || mode_o == 3'h4) [*3];
	endsequence
	// cycles since the bus fell in stop; release does not stop the wake timer
	always @(posedge clk_sys_i) begin
		if (sys_rst_i || wake_cnt == 13'h10CC) wake_cnt <= 13'h0;
		else if (wake_cnt == 13'h0 && $fell(lin_bus_i) && mode_o == 3'h3) wake_cnt <= 13'h1;
		else if (wake_cnt != 13'h0) wake_cnt <= wake_cnt + 13'h1;
	end
	// cycles of continuous dominant transmit input in an active mode
	always @(posedge clk_sys_i) begin
		if (sys_rst_i || txd_i || !(mode_o == 3'h1 || mode_o == 3'h2)) dom_cnt <= 0;
		else dom_cnt <= dom_cnt + 1;
	end
	property p_miso_hiz; cs_n_i [*6] |-> !miso_oe_o; endproperty
	a_miso_hiz: assert property (p_miso_hiz)
		else $error("miso driven while deselected");
	property p_rxd; $stable(lin_bus_i) [*6] |-> rxd_o == lin_bus_i; endproperty
	a_rxd: assert property (p_rxd)
		else $error("receive output differs from bus");
	property p_tx_lowpow; s_lowpow |-> !lin_bus_oe_o; endproperty
	a_tx_lowpow: assert property (p_tx_lowpow)
		else $error("bus driven in a low power mode");
	property p_sw_lowpow; s_lowpow |-> !high_side_switch_o && low_side_switch_o == 2'h0; endproperty
	a_sw_lowpow: assert property (p_sw_lowpow)
		else $error("switch on outside active modes");
	property p_dom_early; dom_cnt > 8 && dom_cnt < TXD_DOM_CYC |-> lin_bus_oe_o; endproperty
	a_dom_early: assert property (p_dom_early)
		else $error("driver off before dominant timeout");
	property p_dom_late; dom_cnt == TXD_DOM_CYC + 8 |-> !lin_bus_oe_o; endproperty
	a_dom_late: assert property (p_dom_late)
		else $error("driver still on after dominant timeout");
	property p_wake_early; wake_cnt != 13'h0 && wake_cnt < 13'h08CA |-> irq_n_o; endproperty
	a_wake_early: assert property (p_wake_early)
		else $error("interrupt too early after bus wake");
	property p_wake_late; wake_cnt == 13'h109A |-> !irq_n_o; endproperty
	a_wake_late: assert property (p_wake_late)
		else $error("interrupt too late after bus wake");
	property p_irq_hold;
		(!irq_n_o && cs_n_i && (mode_o == 3'h1 || mode_o == 3'h2)) [*8] |=> !irq_n_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt released without a read");
	property p_cs_wake; mode_o == 3'h3 && $rose(cs_n_i) |-> ##[1:12] mode_o == 3'h1; endproperty
	a_cs_wake: assert property (p_cs_wake)
		else $error("no wake on select rise in stop");
	property p_rst_drive; mode_o == 3'h0 [*2] |-> rst_n_oe_o; endproperty
	a_rst_drive: assert property (p_rst_drive)
		else $error("reset pin released in reset mode");
	c_cs_wake: cover property (mode_o == 3'h3 ##1 mode_o == 3'h1);
	c_irq: cover property ($fell(irq_n_o));
	c_sleep_wake: cover property (mode_o == 3'h4 ##1 mode_o == 3'h0);
endmodule
bind sbc_link sbc_link_assertions #(.TXD_DOM_CYC(TXD_DOM_CYC)) u_chk (
	.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .miso_oe_o(miso_oe_o),
	.txd_i(txd_i), .lin_bus_i(lin_bus_i), .rxd_o(rxd_o), .lin_bus_oe_o(lin_bus_oe_o),
	.high_side_switch_o(high_side_switch_o), .low_side_switch_o(low_side_switch_o),
	.rst_n_oe_o(rst_n_oe_o), .irq_n_o(irq_n_o), .mode_o(mode_o)
);

// ===== sbc_mcu_model.sv
// Purpose: host controller model on the serial link pins
// Assumes: serial clock idles low, 80 ns period from 4 ns steps
// Notes:   bits read while miso is off come back unknown
`timescale 1ns/1ns
module sbc_mcu_model (
	// clock
	input  wire clk_sys_i,
	// serial link
	output reg  sclk_o,
	output reg  cs_n_o,
	output reg  mosi_o,
	input  wire miso_i,
	input  wire miso_oe_i
);
	integer i;
	// idle: deselected, clock still
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// one frame of nb bits, msb first; bits past the eighth are zero
	task xfer(input [7:0] tx, input integer nb, output [7:0] rx);
		begin
			@(negedge clk_sys_i) cs_n_o = 1'b0; // held low all frame
			for (i = 0; i < nb; i = i + 1) begin // bit count
				mosi_o = (i < 8) ? tx[7 - i] : 1'b0; // change after fall
				repeat (10) @(negedge clk_sys_i);
				sclk_o = 1'b1;
				rx = {rx[6:0], miso_oe_i ? miso_i : 1'bx}; // sample at rise
				repeat (10) @(negedge clk_sys_i);
				sclk_o = 1'b0;
			end
			repeat (10) @(negedge clk_sys_i);
			cs_n_o = 1'b1;
			repeat (12) @(negedge clk_sys_i);
			mosi_o = ~mosi_o; // released line shows no stale level
		end
	endtask
endmodule

// ===== sbc_link_tb_top.sv
// Purpose: self-checking bench for the host link and bus pin block
// Assumes: shortened counts; bus and reset lines pulled up, wired low
// Notes:   stimulus moves on the falling clock edge
`timescale 1ns/1ns
module sbc_link_tb_top;
	reg        clk_sys_i = 1'b0;
	reg        sys_rst_i = 1'b1;
	reg        txd = 1'b1;
	reg        pwm = 1'b1;
	reg        fault = 1'b0;
	reg        int_rst = 1'b0;
	reg        bus_drv = 1'b0;
	reg        rst_drv = 1'b0;
	reg        ce = 1'b1;
	reg  [7:0] rx;
	integer    n_errors = 0;
	integer    num_checks = 0;
	integer    n;
	wire       sclk, cs_n, mosi, miso, miso_oe, rxd, bus_o, bus_oe, hs, rst_o, rst_oe, irq_n;
	wire [1:0] ls, mux;
	wire [2:0] mode;
	// open-drain lines: pulled up, low while either side pulls
	wire       lin_bus = ~bus_oe & ~bus_drv;
	wire       rst_pin = ~rst_oe & ~rst_drv;
	// 250 MHz system clock
	initial forever #2 clk_sys_i = ~clk_sys_i;
	sbc_link #(.BUS_DEGLITCH_CYC(40), .CS_HOLDOFF_CYC(30), .RST_PULSE_CYC(20), .TXD_DOM_CYC(50)) DUT (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .sclk_i(sclk),
		.cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .txd_i(txd),
		.rxd_o(rxd), .lin_bus_i(lin_bus), .lin_bus_o(bus_o), .lin_bus_oe_o(bus_oe),
		.pulse_gate_input_i(pwm), .high_side_switch_o(hs), .low_side_switch_o(ls),
		.rst_n_i(rst_pin), .rst_n_o(rst_o), .rst_n_oe_o(rst_oe), .fault_event_i(fault),
		.internal_reset_req_i(int_rst), .irq_n_o(irq_n), .analog_mux_output_sel_o(mux),
		.mode_o(mode));
	sbc_mcu_model u_mcu (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_i(miso_oe));
	task summarize;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_errors);
			if (n_errors == 0 && num_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task check(input string what, input [7:0] exp, input [7:0] got);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("mismatch %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task wt(input integer c);
		repeat (c) @(negedge clk_sys_i);
	endtask
	task frame(input [7:0] tx, input integer nb = 8);
		u_mcu.xfer(tx, nb, rx);
	endtask
	// bounded wait for a mode; running out ends the run
	task wait_mode(input [2:0] m);
		begin
			n = 0;
			while (mode !== m && n < 400) begin
				@(negedge clk_sys_i);
				n = n + 1;
			end
			if (mode !== m) begin
				n_errors = n_errors + 1;
				$display("mismatch mode_wait expected %h seen %h", m, mode);
				summarize;
			end
		end
	endtask
	initial begin
		wt(12);
		sys_rst_i = 1'b0;
		check("rst_drive", 1, rst_oe); // reset pin pulled
		check("rst_level", 0, rst_o); // pull-down level
		wait_mode(3'h1); // normal request after release
		check("rst_release", 0, rst_oe);
		check("no_gate", 0, {hs, ls}); // gate idle before writes
		frame(8'h80);
		check("status", 8'h20, rx);
		$display("test link done");
		frame(8'h23);
		check("hs_gate_hi", 1, hs);
		wt(12500); // slow gate input
		pwm = 1'b0;
		wt(10);
		check("hs_gate_lo", 0, hs);
		frame(8'h47);
		check("ls_gate_lo", 0, ls);
		frame(8'h43);
		check("ls_on", 3, ls);
		frame(8'h40);
		$display("test switch done");
		for (int k = 0; k < 4; k++) begin
			frame(8'h60 | k[7:0]);
			check("mux", k[7:0], mux);
		end
		frame(8'h62, 7);
		check("mux_short", 3, mux);
		frame(8'h61, 9);
		check("mux_long", 3, mux);
		// with the enable low the whole frame must pass unseen
		ce = 1'b0;
		frame(8'h60);
		ce = 1'b1;
		check("ce_hold", 3, mux);
		check("ce_mode", 1, mode);
		$display("test mux done");
		txd = 1'b0;
		wt(8);
		check("bus_dom", 1, bus_oe);
		check("bus_level", 0, bus_o);
		// bus level needs its own trip through the pin synchroniser
		wt(4);
		check("rxd_dom", 0, rxd);
		wt(62);
		check("dom_lock", 0, bus_oe);
		check("irq_dom", 0, irq_n);
		txd = 1'b1;
		wt(8);
		check("rxd_rec", 1, rxd);
		bus_drv = 1'b1;
		wt(8);
		check("rxd_far", 0, rxd);
		bus_drv = 1'b0;
		fault = 1'b1;
		wt(1);
		fault = 1'b0;
		wt(20);
		check("irq_held", 0, irq_n);
		frame(8'h80);
		check("status_flags", 8'h2C, rx);
		check("irq_clear", 1, irq_n);
		$display("test bus done");
		frame(8'h01);
		check("stop", 3, mode);
		txd = 1'b0;
		wt(8);
		check("tx_stop", 0, bus_oe);
		txd = 1'b1;
		frame(8'h60);
		check("cs_wake", 1, mode);
		check("mux_kept", 3, mux);
		wt(40); // holdoff after wake
		check("irq_cs", 0, irq_n);
		frame(8'h80);
		check("status_cs", 8'h21, rx);
		frame(8'h01);
		check("stop2", 3, mode);
		bus_drv = 1'b1;
		n = 0;
		while (irq_n !== 1'b0 && n < 5000) begin
			@(negedge clk_sys_i);
			n = n + 1;
		end
		check("wake_time", 1, n >= 2250 && n <= 4250);
		if (n >= 5000) summarize;
		wait_mode(3'h1);
		bus_drv = 1'b0;
		wt(1200);
		frame(8'h80);
		check("status_bus", 8'h22, rx);
		$display("test stop done");
		frame(8'h02);
		check("sleep", 4, mode);
		bus_drv = 1'b1;
		wt(20);
		bus_drv = 1'b0;
		wt(30);
		check("glitch", 4, mode);
		bus_drv = 1'b1;
		wt(60);
		check("sleep_wake", 0, mode);
		bus_drv = 1'b0;
		check("sleep_rst", 1, rst_oe);
		wait_mode(3'h1);
		$display("test sleep done");
		frame(8'h00);
		check("normal", 2, mode);
		rst_drv = 1'b1;
		wt(50);
		rst_drv = 1'b0;
		wt(10);
		check("rst_glitch", 2, mode);
		rst_drv = 1'b1;
		wt(200);
		rst_drv = 1'b0;
		check("ext_rst", 1, mode);
		int_rst = 1'b1;
		wait_mode(3'h0);
		int_rst = 1'b0;
		check("int_rst", 1, rst_oe);
		wait_mode(3'h1);
		$display("test reset done");
		summarize;
	end
endmodule
